// [ops_supervisor.sv]
// Reverse-mode control and protection supervisor with its register file.
`default_nettype none
module ops_supervisor
   import ops_pkg::*;
#(
   parameter int LONG_CYC = CYC_LONG,
   parameter int SHORT_CYC = CYC_SHORT,
   parameter int WIN_CYC = CYC_WIN
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Register port: one access per strobe
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   output logic [15:0] o_reg_rdata,
   // Analog comparator events
   input wire logic i_reverse_mode_enable_pin,
   input wire logic i_battery_above_min,
   input wire logic i_battery_absent_input,
   input wire logic i_single_cell,
   input wire logic i_adapter_present,
   input wire logic i_rev_out_above_uv,
   input wire logic i_rev_out_above_rise,
   input wire logic i_rev_out_above_ov,
   input wire logic i_rev_out_above_fall,
   input wire logic i_input_sense_above_ov,
   input wire logic i_comparator_above_ref,
   input wire logic i_adapter_above_ov,
   input wire logic i_adapter_above_rec,
   input wire logic i_system_above_ov,
   input wire logic i_system_above_rec,
   input wire logic i_adapter_over_current,
   input wire logic i_battery_over_current,
   input wire logic i_temp_above_hot,
   input wire logic i_temp_above_cool,
   // Power stage controls
   output logic o_reverse_switching,
   output logic o_forward_enable,
   output logic o_adapter_switch_gate,
   output logic o_battery_switch_gate,
   output logic o_adapter_ok_output,
   output logic o_regulator_enable,
   output logic o_comparator_ref_high,
   output logic o_shared_pin_output,
   output logic [15:0] o_reverse_output_voltage,
   output logic [15:0] o_reverse_output_current
);

   typedef enum logic [3:0] {
      RV_OFF = 4'b0001,
      RV_DEB = 4'b0010,
      RV_RUN = 4'b0100,
      RV_HOLD = 4'b1000
   } ops_rev_t;

   ////////////////////////////////////////////////////////////////////////////
   // Register file
   logic [15:0] ctl1_reg, ctl1_next, ctl2_reg, ctl2_next;
   logic [15:0] rv_reg, rv_next, rc_reg, rc_next, rdata_reg, rdata_next;
   logic [15:0] info_w;

   // Writes land on the addressed word; reads are registered
   always_comb begin
      ctl1_next = ctl1_reg;
      ctl2_next = ctl2_reg;
      rv_next = rv_reg;
      rc_next = rc_reg;
      rdata_next = rdata_reg;
      if (i_reg_wr) begin
         unique case (i_reg_addr)
            REG_CTL1: ctl1_next = i_reg_wdata;
            REG_CTL2: ctl2_next = i_reg_wdata;
            REG_RVOLT: rv_next = i_reg_wdata;
            REG_RCURR: rc_next = i_reg_wdata;
            default: ;
         endcase
      end
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            REG_INFO: rdata_next = info_w;
            REG_CTL1: rdata_next = ctl1_reg;
            REG_CTL2: rdata_next = ctl2_reg;
            REG_RVOLT: rdata_next = rv_reg;
            REG_RCURR: rdata_next = rc_reg;
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         ctl1_reg <= CTL_RST;
         ctl2_reg <= CTL_RST;
         rv_reg <= RVOLT_RST;
         rc_reg <= RCURR_RST;
         rdata_reg <= 16'h0000;
      end else begin
         ctl1_reg <= ctl1_next;
         ctl2_reg <= ctl2_next;
         rv_reg <= rv_next;
         rc_reg <= rc_next;
         rdata_reg <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin sharing and comparator
   logic rev_cmd, cmp_dis, pins_rev, ref_on, cmp_active, cmp_out;
   assign rev_cmd = ctl1_reg[C1_REV_EN];
   assign cmp_dis = ctl2_reg[C2_CMP_DIS];
   assign pins_rev = rev_cmd & cmp_dis;
   // Reference only exists with an adapter or the power monitor on
   assign ref_on = i_adapter_present | ctl1_reg[C1_MON_EN];
   assign cmp_active = ~cmp_dis & ref_on;
   assign cmp_out = i_comparator_above_ref ^ ctl2_reg[C2_CMP_POL];

   ////////////////////////////////////////////////////////////////////////////
   // Counters for protection windows
   logic [31:0] rdeb_reg, rdeb_next, ovr_reg, ovr_next, adp_reg, adp_next;
   logic [31:0] slot_reg, slot_next, win_reg, win_next, oct_reg, oct_next;
   logic [31:0] hot_reg, hot_next;
   logic [2:0] wcnt_reg, wcnt_next;
   logic adp_ov_reg, adp_ov_next, sys_ov_reg, sys_ov_next, hot_f_reg, hot_f_next;
   logic oc_f_reg, oc_f_next, slot_used_reg, slot_used_next, rov_reg, rov_next;
   ops_rev_t rst_reg, rst_next;
   logic rev_ok, rev_trip, oc_hit, deb_done;
   logic [31:0] deb_len;

   assign deb_len = ctl2_reg[C2_DEB_SEL] ? 32'(SHORT_CYC) : 32'(LONG_CYC);
   // Enable needs pin only when pins are in reverse mode
   assign rev_ok = rev_cmd & (i_reverse_mode_enable_pin | ~pins_rev)
      & ~(cmp_dis & ~rev_cmd) & i_battery_above_min
      & ~i_battery_absent_input & ~i_single_cell;
   assign oc_hit = (i_adapter_over_current | i_battery_over_current)
      & ~ctl2_reg[C2_WAY_OVERCURRENT_PROTECTION_DIS];
   assign rev_trip = ~i_rev_out_above_uv;
   assign deb_done = rdeb_reg >= deb_len - 32'd1;

   // Protection state next values
   always_comb begin
      adp_next = adp_reg;
      adp_ov_next = adp_ov_reg;
      sys_ov_next = sys_ov_reg;
      hot_next = hot_reg;
      hot_f_next = hot_f_reg;
      slot_next = slot_reg;
      slot_used_next = slot_used_reg;
      win_next = win_reg;
      wcnt_next = wcnt_reg;
      oc_f_next = oc_f_reg;
      oct_next = oct_reg;
      // Adapter overvoltage with qualify and recovery timers
      if (!adp_ov_reg) begin
         adp_next = i_adapter_above_ov ? adp_reg + 32'd1 : 32'd0;
         if (i_adapter_above_ov && adp_reg >= 32'(CYC_ADPOV)) begin
            adp_ov_next = 1'b1;
            adp_next = 32'd0;
         end
      end else begin
         adp_next = i_adapter_above_rec ? 32'd0 : adp_reg + 32'd1;
         if (!i_adapter_above_rec && adp_reg >= 32'(CYC_REC)) begin
            adp_ov_next = 1'b0;
            adp_next = 32'd0;
         end
      end
      // Hysteresis comparators give the two thresholds
      if (i_system_above_ov) sys_ov_next = 1'b1;
      else if (!i_system_above_rec) sys_ov_next = 1'b0;
      // Thermal shutdown and delayed restart
      if (i_temp_above_hot) begin
         hot_f_next = 1'b1;
         hot_next = 32'd0;
      end else if (hot_f_reg) begin
         hot_next = i_temp_above_cool ? 32'd0 : hot_reg + 32'd1;
         if (!i_temp_above_cool && hot_reg >= 32'(CYC_REC) - 32'd1) hot_f_next = 1'b0;
      end
      // One count per slot inside the rolling window
      slot_next = (slot_reg >= 32'(CYC_SLOT) - 32'd1) ? 32'd0 : slot_reg + 32'd1;
      if (slot_reg >= 32'(CYC_SLOT) - 32'd1) slot_used_next = 1'b0;
      win_next = (win_reg >= 32'(WIN_CYC) - 32'd1) ? 32'd0 : win_reg + 32'd1;
      if (win_reg >= 32'(WIN_CYC) - 32'd1) wcnt_next = 3'd0;
      if (oc_f_reg) begin
         oct_next = oct_reg + 32'd1;
         if (oct_reg >= (ctl2_reg[C2_RETRY_SEL] ? 32'(SHORT_CYC) : 32'(LONG_CYC)) - 32'd1) begin
            oc_f_next = 1'b0;
            oct_next = 32'd0;
            wcnt_next = 3'd0;
         end
      end else if (oc_hit && !slot_used_reg) begin
         slot_used_next = 1'b1;
         wcnt_next = wcnt_reg + 3'd1;
         if (wcnt_reg == 3'(WOC_LIMIT - 1)) begin
            oc_f_next = 1'b1;
            oct_next = 32'd0;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         adp_reg <= 32'd0;
         adp_ov_reg <= 1'b0;
         sys_ov_reg <= 1'b0;
         hot_reg <= 32'd0;
         hot_f_reg <= 1'b0;
         slot_reg <= 32'd0;
         slot_used_reg <= 1'b0;
         win_reg <= 32'd0;
         wcnt_reg <= 3'd0;
         oc_f_reg <= 1'b0;
         oct_reg <= 32'd0;
      end else begin
         adp_reg <= adp_next;
         adp_ov_reg <= adp_ov_next;
         sys_ov_reg <= sys_ov_next;
         hot_reg <= hot_next;
         hot_f_reg <= hot_f_next;
         slot_reg <= slot_next;
         slot_used_reg <= slot_used_next;
         win_reg <= win_next;
         wcnt_reg <= wcnt_next;
         oc_f_reg <= oc_f_next;
         oct_reg <= oct_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reverse mode sequencer
   logic fault_any;
   assign fault_any = adp_ov_reg | sys_ov_reg | hot_f_reg | oc_f_reg;

   always_comb begin
      rst_next = rst_reg;
      rdeb_next = rdeb_reg;
      rov_next = rov_reg;
      ovr_next = ovr_reg;
      unique case (rst_reg)
         RV_OFF: begin
            rdeb_next = 32'd0;
            if (rev_ok) rst_next = RV_DEB;
         end
         RV_DEB: begin
            // Debounce restarts while the output sits below the rising level
            rdeb_next = (i_rev_out_above_rise || rdeb_reg == 32'd0) ? rdeb_reg + 32'd1
               : 32'd0;
            if (!rev_ok) rst_next = RV_OFF;
            else if (deb_done && !i_input_sense_above_ov) rst_next = RV_RUN;
         end
         RV_RUN: begin
            if (!rev_ok) rst_next = RV_OFF;
            else if (rev_trip) begin
               rst_next = RV_DEB;
               rdeb_next = 32'd0;
            end else if (i_rev_out_above_ov) begin
               rst_next = RV_HOLD;
               ovr_next = 32'd0;
            end
         end
         RV_HOLD: begin
            ovr_next = i_rev_out_above_fall ? 32'd0 : ovr_reg + 32'd1;
            if (!rev_ok) rst_next = RV_OFF;
            else if (!i_rev_out_above_fall && ovr_reg >= 32'(CYC_REC) - 32'd1)
               rst_next = RV_RUN;
         end
      endcase
      rov_next = (rst_next == RV_RUN);
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         rst_reg <= RV_OFF;
         rdeb_reg <= 32'd0;
         ovr_reg <= 32'd0;
         rov_reg <= 1'b0;
      end else begin
         rst_reg <= rst_next;
         rdeb_reg <= rdeb_next;
         ovr_reg <= ovr_next;
         rov_reg <= rov_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   logic pg, rev_gate_cut;
   assign pg = rov_reg & i_rev_out_above_uv & ~i_rev_out_above_ov;
   // Gate is cut in the debounce state once counting starts or while the output is below the rising level, so a retry never feeds a short
   assign rev_gate_cut = (rst_reg == RV_DEB)
      && (rdeb_reg != 32'd0 || !i_rev_out_above_rise);
   assign info_w = {ref_on, 8'h00, (rst_reg != RV_OFF) ? INF_MODE_REV : 2'h0,
      5'h00};

   // Switching is vetoed by any protection latch
   always_comb begin
      o_reverse_switching = rov_reg & ~fault_any;
      o_forward_enable = (rst_reg == RV_OFF) & ~fault_any & i_adapter_present;
      o_adapter_switch_gate = ~ctl2_reg[C2_GATE_OFF] & ~adp_ov_reg
         & ~oc_f_reg & ~rev_gate_cut;
      o_battery_switch_gate = adp_ov_reg | ~i_adapter_present;
      o_adapter_ok_output = i_adapter_present & ~adp_ov_reg & ~oc_f_reg;
      o_regulator_enable = ~hot_f_reg;
      o_comparator_ref_high = ~ctl2_reg[C2_CMP_REF];
      // Comparator mode gives no power good indication
      o_shared_pin_output = pins_rev ? pg : (cmp_active & cmp_out);
      o_reg_rdata = rdata_reg;
      o_reverse_output_voltage = rv_reg;
      o_reverse_output_current = rc_reg;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_run_needs_ok: assert property (@(posedge i_core_clk) disable iff (i_rst)
      o_reverse_switching |-> $past(rev_ok))
      else $error("run without enable");
   a_deb_no_early: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (rst_reg == RV_DEB && !deb_done) |=> !rov_reg)
      else $error("debounce cut short");
   a_pg_window: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (pins_rev && o_shared_pin_output) |-> i_rev_out_above_uv && !i_rev_out_above_ov)
      else $error("pg out of window");
   a_gate_off_bit: assert property (@(posedge i_core_clk) disable iff (i_rst)
      ctl2_reg[C2_GATE_OFF] |-> !o_adapter_switch_gate)
      else $error("gate not off");
   a_sense_block: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (rst_reg == RV_DEB && i_input_sense_above_ov) |=> !rov_reg)
      else $error("run with input sense high");
   a_uv_stop: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (rst_reg == RV_RUN && rev_trip) |=> !o_reverse_switching && !pg)
      else $error("uv not stopped");
   a_ovp_stop: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (rst_reg == RV_RUN && i_rev_out_above_ov && rev_ok && !rev_trip) |=> !rov_reg)
      else $error("ov not stopped");
   a_cell_block: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (i_battery_absent_input || i_single_cell) |=> !o_reverse_switching)
      else $error("run while blocked");
   a_woc_trip: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (!oc_f_reg && oc_hit && !slot_used_reg && wcnt_reg == 3'(WOC_LIMIT - 1))
      |=> !o_adapter_ok_output && !o_adapter_switch_gate) else $error("woc not tripped");
   a_oc_disable: assert property (@(posedge i_core_clk) disable iff (i_rst)
      ctl2_reg[C2_WAY_OVERCURRENT_PROTECTION_DIS] && !oc_f_reg |=> !oc_f_reg)
      else $error("oc while off");
   a_adp_ov_gate: assert property (@(posedge i_core_clk) disable iff (i_rst)
      adp_ov_reg |-> !o_adapter_switch_gate && !o_adapter_ok_output && o_battery_switch_gate)
      else $error("adp ov outputs");
   a_hot_stop: assert property (@(posedge i_core_clk) disable iff (i_rst)
      i_temp_above_hot |=> !o_regulator_enable && !o_reverse_switching)
      else $error("hot not stopped");
   a_cmp_polarity: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (!pins_rev && cmp_active) |-> o_shared_pin_output ==
      (i_comparator_above_ref ^ ctl2_reg[C2_CMP_POL])) else $error("cmp polarity");

endmodule // ops_supervisor
`default_nettype wire

// [ops_pkg.sv]
// Package for the reverse-mode and protection supervisor: register map, fields, timing.
`default_nettype none
package ops_pkg;
   // Register offsets on the documented register port
   localparam logic [7:0] REG_INFO = 8'h3a;
   localparam logic [7:0] REG_CTL1 = 8'h3c;
   localparam logic [7:0] REG_CTL2 = 8'h3d;
   localparam logic [7:0] REG_RVOLT = 8'h49;
   localparam logic [7:0] REG_RCURR = 8'h4a;
   // First control word fields
   localparam int C1_MON_EN = 3;
   localparam int C1_REV_EN = 11;
   // Second control word fields
   localparam int C2_WAY_OVERCURRENT_PROTECTION_DIS = 1;
   localparam int C2_CMP_POL = 2;
   localparam int C2_CMP_DIS = 3;
   localparam int C2_CMP_REF = 4;
   localparam int C2_GATE_OFF = 5;
   localparam int C2_RETRY_SEL = 11;
   localparam int C2_DEB_SEL = 13;
   // Information fields
   localparam int INF_MODE_LO = 5;
   localparam int INF_MODE_HI = 6;
   localparam int INF_REF_ON = 15;
   localparam logic [1:0] INF_MODE_REV = 2'h3;
   // Reset values; voltage and current codes in 1 mV and 1 mA steps
   localparam logic [15:0] CTL_RST = 16'h0000;
   localparam logic [15:0] RVOLT_RST = 16'h1400;
   localparam logic [15:0] RCURR_RST = 16'h0200;
   // Timing constants in their own units, converted with the clock rate
   localparam int CLK_HZ = 25_000_000;
   localparam int T_LONG_MS = 1300;
   localparam int T_SHORT_MS = 150;
   localparam int T_WIN_MS = 656;
   localparam int T_REC_US = 100;
   localparam int T_ADPOV_US = 10;
   localparam int T_OCSLOT_US = 20;
   localparam int WOC_LIMIT = 7;
   localparam int CYC_LONG = CLK_HZ / 1000 * T_LONG_MS;
   localparam int CYC_SHORT = CLK_HZ / 1000 * T_SHORT_MS;
   localparam int CYC_WIN = CLK_HZ / 1000 * T_WIN_MS;
   localparam int CYC_REC = CLK_HZ / 1_000_000 * T_REC_US;
   localparam int CYC_ADPOV = CLK_HZ / 1_000_000 * T_ADPOV_US;
   localparam int CYC_SLOT = CLK_HZ / 1_000_000 * T_OCSLOT_US;
endpackage
`default_nettype wire

// [ops_port_model.sv]
// Stand-in for the reverse output port and its four threshold comparators.
`default_nettype none
module ops_port_model (
   input wire logic [15:0] i_level_mv,
   output logic o_above_uv,
   output logic o_above_rise,
   output logic o_above_ov,
   output logic o_above_fall
);
   timeunit 1ns;
   timeprecision 1ns;
   ////////////////////////////////////////////////////////////////////////////////
   // Port level is held by the bench; the load is stiff so it ignores switching
   assign o_above_uv = i_level_mv > 16'h1068;
   assign o_above_rise = i_level_mv > 16'h1194;
   assign o_above_ov = i_level_mv > 16'h1770;
   assign o_above_fall = i_level_mv > 16'h1644;
endmodule // ops_port_model
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the reverse-mode and protection supervisor.
`default_nettype none
module testbench import ops_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, wr = 0, rd = 0, pin = 0, bat = 1, gone = 0, one = 0, adapter_voltage_sense = 1;
   logic insov = 0, cmp = 0, aov = 0, arec = 0, sov = 0, srec = 0, aoc = 0, boc = 0;
   logic hot = 0, cool = 0, uv, rise, ov, fall, sw, fwd, agate, battery_switch_gate, aok, ldo, refh, shp;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000, lvl = 16'h1400, rdata, rv, rc;
   int error_cnt = 0, compares = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, design and port stand-in
   always #20 clk = ~clk;
   ops_supervisor #(.LONG_CYC(100), .SHORT_CYC(50), .WIN_CYC(60000)) dut (
      .i_core_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_reverse_mode_enable_pin(pin),
      .i_battery_above_min(bat), .i_battery_absent_input(gone), .i_single_cell(one),
      .i_adapter_present(adapter_voltage_sense), .i_rev_out_above_uv(uv), .i_rev_out_above_rise(rise),
      .i_rev_out_above_ov(ov), .i_rev_out_above_fall(fall), .i_input_sense_above_ov(insov),
      .i_comparator_above_ref(cmp), .i_adapter_above_ov(aov), .i_adapter_above_rec(arec),
      .i_system_above_ov(sov), .i_system_above_rec(srec), .i_adapter_over_current(aoc),
      .i_battery_over_current(boc), .i_temp_above_hot(hot), .i_temp_above_cool(cool),
      .o_reverse_switching(sw), .o_forward_enable(fwd), .o_adapter_switch_gate(agate),
      .o_battery_switch_gate(battery_switch_gate), .o_adapter_ok_output(aok), .o_regulator_enable(ldo),
      .o_comparator_ref_high(refh), .o_shared_pin_output(shp),
      .o_reverse_output_voltage(rv), .o_reverse_output_current(rc));
   ops_port_model port (.i_level_mv(lvl), .o_above_uv(uv), .o_above_rise(rise),
      .o_above_ov(ov), .o_above_fall(fall));
   ////////////////////////////////////////////////////////////////////////////////
   // Shared helpers; inputs move on the falling edge only
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wreg(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      wr = 1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr = 0;
   endtask
   // Read data is registered, so it is taken one edge after the strobe
   task automatic rchk(input string what, input logic [7:0] a, input logic [15:0] exp);
      @(negedge clk);
      rd = 1;
      addr = a;
      @(negedge clk);
      rd = 0;
      chk(what, exp, rdata);
   endtask
   task automatic test_done;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_regs;
      rchk("volt rst", REG_RVOLT, RVOLT_RST);
      rchk("curr rst", REG_RCURR, RCURR_RST);
      wreg(REG_RVOLT, 16'h1388);
      rchk("volt wr", REG_RVOLT, 16'h1388);
      chk("volt port", 16'h1388, rv);
      wreg(REG_RCURR, 16'h03e8);
      chk("curr port", 16'h03e8, rc);
      rchk("unmapped", 8'h50, 16'h0000);
   endtask
   task automatic t_sys;
      chk("fwd idle", 1, fwd);
      sov = 1;
      srec = 1;
      cyc(3);
      chk("sys ov", 0, fwd);
      sov = 0;
      cyc(3);
      chk("sys hyst", 0, fwd);
      srec = 0;
      cyc(3);
      chk("sys back", 1, fwd);
   endtask
   task automatic t_hot;
      hot = 1;
      cool = 1;
      cyc(2);
      chk("hot ldo", 0, ldo);
      chk("hot fwd", 0, fwd);
      hot = 0;
      cyc(2400);
      chk("warm ldo", 0, ldo);
      cool = 0;
      cyc(2400);
      chk("cool wait", 0, ldo);
      cyc(200);
      chk("cool ldo", 1, ldo);
      chk("cool fwd", 1, fwd);
   endtask
   task automatic t_adpov;
      aov = 1;
      arec = 1;
      cyc(200);
      chk("aov early", 1, aok);
      cyc(100);
      chk("aov ok", 0, aok);
      chk("aov gate", 0, agate);
      chk("aov bat", 1, battery_switch_gate);
      chk("aov fwd", 0, fwd);
      aov = 0;
      cyc(3000);
      chk("aov band", 0, aok);
      arec = 0;
      cyc(2400);
      chk("aov wait", 0, aok);
      cyc(200);
      chk("aov back", 1, aok);
      chk("aov gate on", 1, agate);
   endtask
   // Adapter source with short retry, then battery source with long retry
   task automatic t_woc;
      int n;
      logic in_span;
      for (int s = 0; s < 2; s++) begin
         wreg(REG_CTL2, s == 0 ? 16'h0800 : 16'h0000);
         aoc = (s == 0);
         boc = (s == 1);
         n = 0;
         while (aok === 1'b1 && n < 4000) begin
            cyc(1);
            n++;
         end
         // Seven counts, one per slot, span more than five and at most seven slots
         in_span = n > 5 * CYC_SLOT && n <= 7 * CYC_SLOT + 1;
         chk("woc slots", 1, 16'(in_span));
         chk("woc gate", 0, agate);
         chk("woc fwd", 0, fwd);
         aoc = 0;
         boc = 0;
         cyc(75);
         chk("woc retry", s == 0, aok);
         cyc(100);
         chk("woc up", 1, aok);
      end
      wreg(REG_CTL2, 16'h0002);
      aoc = 1;
      cyc(4000);
      chk("woc off", 1, aok);
      aoc = 0;
   endtask
   task automatic t_mon;
      adapter_voltage_sense = 0;
      cmp = 1;
      cyc(2);
      chk("mon off", 0, shp);
      rchk("ref off", REG_INFO, 16'h0000);
      wreg(REG_CTL1, 16'h0008);
      chk("mon on", 1, shp);
      rchk("ref on", REG_INFO, 16'h8000);
      adapter_voltage_sense = 1;
   endtask
   // Reverse mode running beside the comparator, both polarities
   task automatic t_cmp;
      wreg(REG_CTL2, 16'h2000);
      wreg(REG_CTL1, 16'h0800);
      cyc(70);
      chk("no pin run", 1, sw);
      rchk("mode", REG_INFO, 16'h8060);
      chk("ref 2v", 1, refh);
      for (int p = 0; p < 2; p++) begin
         wreg(REG_CTL2, p ? 16'h2004 : 16'h2000);
         for (int c = 0; c < 2; c++) begin
            cmp = c[0];
            cyc(2);
            chk("cmp out", 16'(c ^ p), shp);
         end
      end
      wreg(REG_CTL2, 16'h2010);
      chk("ref 1v2", 0, refh);
      wreg(REG_CTL1, 16'h0000);
      wreg(REG_CTL2, 16'h0008);
      cmp = 1;
      cyc(2);
      chk("both off", 0, shp);
      chk("both off sw", 0, sw);
   endtask
   task automatic t_start;
      wreg(REG_CTL2, 16'h2008);
      insov = 1;
      pin = 1;
      wreg(REG_CTL1, 16'h0800);
      cyc(40);
      chk("debounce", 0, sw);
      cyc(30);
      chk("sense high", 0, sw);
      insov = 0;
      cyc(3);
      chk("run", 1, sw);
      chk("pg", 1, shp);
   endtask
   task automatic t_faults;
      lvl = 16'h0fa0;
      cyc(3);
      chk("uv sw", 0, sw);
      chk("uv pg", 0, shp);
      chk("uv gate", 0, agate);
      lvl = 16'h1388;
      cyc(40);
      chk("uv deb", 0, sw);
      cyc(30);
      chk("uv back", 1, sw);
      lvl = 16'h1964;
      cyc(3);
      chk("ov sw", 0, sw);
      chk("ov pg", 0, shp);
      lvl = 16'h157c;
      cyc(2400);
      chk("ov wait", 0, sw);
      cyc(200);
      chk("ov back", 1, sw);
      wreg(REG_CTL2, 16'h2028);
      chk("gate cut", 0, agate);
      wreg(REG_CTL2, 16'h2008);
      chk("gate on", 1, agate);
   endtask
   // Each blocking condition in turn, then a fresh debounced start; last the long debounce
   task automatic t_block;
      for (int i = 0; i < 4; i++) begin
         gone = (i == 0);
         one = (i == 1);
         bat = (i != 2);
         pin = (i != 3);
         cyc(3);
         chk("blocked", 0, sw);
         gone = 0;
         one = 0;
         bat = 1;
         pin = 1;
         cyc(70);
         chk("rerun", 1, sw);
      end
      wreg(REG_CTL2, 16'h0008);
      gone = 1;
      cyc(3);
      chk("long off", 0, sw);
      gone = 0;
      cyc(70);
      chk("long deb", 0, sw);
      cyc(40);
      chk("long run", 1, sw);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence and watchdog
   initial begin
      repeat (3) @(negedge clk);
      rst = 0;
      t_regs();
      t_sys();
      t_hot();
      t_adpov();
      t_woc();
      t_mon();
      t_cmp();
      t_start();
      t_faults();
      t_block();
      test_done();
   end
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      test_done();
   end
endmodule // testbench
`default_nettype wire
